// >>> core/irq_prio_pkg.sv
// Register map, field layout and reset values for the interrupt priority slice
package irq_prio_pkg;
	localparam logic [3:0]  ADDR_PRIO3    = 4'h0;
	localparam logic [3:0]  ADDR_PRIO4    = 4'h4;
	localparam logic [31:0] PRIO_RESET    = 32'h0000_0000;
	localparam logic [31:0] PRIO_WR_MASK  = 32'h1F1F_1F1F;
	localparam int          PRIO_W        = 3;
	localparam int          SUB_W         = 2;
	localparam int          SRC0_SUB_LSB  = 0;
	localparam int          SRC0_PRIO_LSB = 2;
	localparam int          SRC1_SUB_LSB  = 8;
	localparam int          SRC1_PRIO_LSB = 10;
	localparam int          SRC2_SUB_LSB  = 16;
	localparam int          SRC2_PRIO_LSB = 18;
	localparam int          SRC3_SUB_LSB  = 24;
	localparam int          SRC3_PRIO_LSB = 26;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : irq_prio_pkg

// >>> core/interrupt_priority_ctrl_slice.sv
// Interrupt priority and subpriority registers for the number-3 and number-4 sources
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps

module interrupt_priority_ctrl_slice
	import irq_prio_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [3:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic [2:0]       ext_irq3_priority_o,
	output logic [1:0]       ext_irq3_subpriority_o,
	output logic [2:0]       out_compare3_priority_o,
	output logic [1:0]       out_compare3_subpriority_o,
	output logic [2:0]       in_capture3_priority_o,
	output logic [1:0]       in_capture3_subpriority_o,
	output logic [2:0]       timer3_priority_o,
	output logic [1:0]       timer3_subpriority_o,
	output logic [31:0]      prio4_fields_o,
	output logic [3:0]       src3_enabled_o
);

	// One record holds all state: bus holding slots, responses, both registers, enables
	typedef struct packed {
		logic        aw_full;
		logic [3:0]  aw_addr;
		logic        w_full;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [31:0] prio3;
		logic [31:0] prio4;
		logic [3:0]  enabled;
		logic        aw_ready;
		logic        w_ready;
		logic        ar_ready;
	} state_t;

	// Present value and next value of that record
	state_t state_reg;
	state_t state_next;

	// Byte-lane merge; reserved bits are forced to zero so they always read back as zero
	function automatic logic [31:0] merge_write(input logic [31:0] old_val,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res & PRIO_WR_MASK;
	endfunction : merge_write

	// Word decode shared by the write and the read path; only aligned word addresses hit,
	// so a byte offset inside a word is refused rather than aliased onto the register
	function automatic logic hits_reg3(input logic [3:0] addr);
		return addr == ADDR_PRIO3;
	endfunction : hits_reg3

	// The number-4 register is stored and read back only; its fields feed nothing here,
	// the consumer of both registers sits outside this block
	function automatic logic hits_reg4(input logic [3:0] addr);
		return addr == ADDR_PRIO4;
	endfunction : hits_reg4

	// zero code disables
	// Any nonzero level counts as enabled, so the arbiter never sees a level-zero source
	function automatic logic prio_enabled(input logic [31:0] word, input int lsb);
		return |word[lsb +: PRIO_W];
	endfunction : prio_enabled

	// three-bit level
	// The level code is handed on unchanged: code seven is level seven, code one level one
	function automatic logic [2:0] prio_field(input logic [31:0] word, input int lsb);
		return word[lsb +: PRIO_W];
	endfunction : prio_field

	// two-bit subpriority
	// The subpriority only orders sources of equal level; it never enables a source itself
	function automatic logic [1:0] sub_field(input logic [31:0] word, input int lsb);
		return word[lsb +: SUB_W];
	endfunction : sub_field

	// Next state: address and data are latched independently, response once both are held
	// Waiting for both halves costs one cycle per write but lets the master offer them in
	// either order; a new address or data word is taken only once its slot is free again
	always_comb begin
		state_next = state_reg;
		if (s_axi_awvalid_i && !state_reg.aw_full) begin
			state_next.aw_full = 1'b1;
			state_next.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && !state_reg.w_full) begin
			state_next.w_full = 1'b1;
			state_next.w_data = s_axi_wdata_i;
			state_next.w_strb = s_axi_wstrb_i;
		end
		// The response stands until the master has taken it
		if (state_reg.bvalid && s_axi_bready_i) begin
			state_next.bvalid = 1'b0;
		end
		if (state_reg.aw_full && state_reg.w_full && !state_reg.bvalid) begin
			state_next.aw_full = 1'b0;
			state_next.w_full  = 1'b0;
			state_next.bvalid  = 1'b1;
			state_next.bresp   = RESP_OKAY;
			if (hits_reg3(state_reg.aw_addr)) begin
				state_next.prio3 = merge_write(state_reg.prio3, state_reg.w_data,
					state_reg.w_strb);
			end else if (hits_reg4(state_reg.aw_addr)) begin
				state_next.prio4 = merge_write(state_reg.prio4, state_reg.w_data,
					state_reg.w_strb);
			end else begin
				// Unmapped word: nothing is stored, the master sees an error
				state_next.bresp = RESP_SLVERR;
			end
		end
		// Read path; unmapped addresses answer zero with an error
		// A read returns the value held before this edge; a write landing now shows next read
		if (state_reg.rvalid && s_axi_rready_i) begin
			state_next.rvalid = 1'b0;
		end
		// A new read is taken only once the previous answer is gone
		if (s_axi_arvalid_i && !state_reg.rvalid) begin
			state_next.rvalid = 1'b1;
			state_next.rresp  = RESP_OKAY;
			if (hits_reg3(s_axi_araddr_i)) begin
				state_next.rdata = state_reg.prio3;
			end else if (hits_reg4(s_axi_araddr_i)) begin
				state_next.rdata = state_reg.prio4;
			end else begin
				state_next.rdata = 32'h0000_0000;
				state_next.rresp = RESP_SLVERR;
			end
		end
		// zero code disables
		// Enables follow the next register value so they change on the same edge as the fields
		// They are derived, so software cannot set one apart from its level
		state_next.enabled[0] = prio_enabled(state_next.prio3, SRC0_PRIO_LSB);
		state_next.enabled[1] = prio_enabled(state_next.prio3, SRC1_PRIO_LSB);
		state_next.enabled[2] = prio_enabled(state_next.prio3, SRC2_PRIO_LSB);
		state_next.enabled[3] = prio_enabled(state_next.prio3, SRC3_PRIO_LSB);
		// Readies are flops of their own so that every port comes straight from a register;
		// each one is high exactly while its holding slot is empty
		state_next.aw_ready = !state_next.aw_full;
		state_next.w_ready  = !state_next.w_full;
		state_next.ar_ready = !state_next.rvalid;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg       <= '0;
			state_reg.prio3 <= PRIO_RESET;
			state_reg.prio4 <= PRIO_RESET;
			// Readies leave reset high: a request may be taken at the first edge after it
			state_reg.aw_ready <= 1'b1;
			state_reg.w_ready  <= 1'b1;
			state_reg.ar_ready <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Ready only while the holding slot is empty, so each channel takes one item at a time
	assign s_axi_awready_o = state_reg.aw_ready;
	assign s_axi_wready_o  = state_reg.w_ready;
	assign s_axi_arready_o = state_reg.ar_ready;
	// Response and read channels come straight from their holding flops
	assign s_axi_bvalid_o  = state_reg.bvalid;
	assign s_axi_bresp_o   = state_reg.bresp;
	assign s_axi_rvalid_o  = state_reg.rvalid;
	assign s_axi_rresp_o   = state_reg.rresp;
	assign s_axi_rdata_o   = state_reg.rdata;

	// priority and subpriority fields out
	// Plain slices of the register, so every field moves on the edge its write lands
	assign timer3_priority_o          = prio_field(state_reg.prio3, SRC0_PRIO_LSB);
	assign timer3_subpriority_o       = sub_field(state_reg.prio3, SRC0_SUB_LSB);
	assign in_capture3_priority_o     = prio_field(state_reg.prio3, SRC1_PRIO_LSB);
	assign in_capture3_subpriority_o  = sub_field(state_reg.prio3, SRC1_SUB_LSB);
	assign out_compare3_priority_o    = prio_field(state_reg.prio3, SRC2_PRIO_LSB);
	assign out_compare3_subpriority_o = sub_field(state_reg.prio3, SRC2_SUB_LSB);
	assign ext_irq3_priority_o        = prio_field(state_reg.prio3, SRC3_PRIO_LSB);
	assign ext_irq3_subpriority_o     = sub_field(state_reg.prio3, SRC3_SUB_LSB);
	assign prio4_fields_o             = state_reg.prio4;
	assign src3_enabled_o             = state_reg.enabled; // Bit0 timer3 .. bit3 ext irq3

endmodule : interrupt_priority_ctrl_slice

// >>> tb/irq_prio_properties.sv
// Port assertions for the interrupt priority slice
`timescale 1ns/10ps
module irq_prio_checker
	import irq_prio_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [2:0]  ext_irq3_priority_o,
	input wire logic [2:0]  out_compare3_priority_o,
	input wire logic [2:0]  in_capture3_priority_o,
	input wire logic [2:0]  timer3_priority_o,
	input wire logic [1:0]  ext_irq3_subpriority_o,
	input wire logic [1:0]  out_compare3_subpriority_o,
	input wire logic [1:0]  in_capture3_subpriority_o,
	input wire logic [1:0]  timer3_subpriority_o,
	input wire logic [31:0] prio4_fields_o,
	input wire logic [3:0]  src3_enabled_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_en_timer: assert property (src3_enabled_o[0] == |timer3_priority_o)
		else $error("timer enable wrong");
	chk_en_capture: assert property (src3_enabled_o[1] == |in_capture3_priority_o)
		else $error("capture enable wrong");
	chk_en_upper: assert property
		(src3_enabled_o[3:2] == {|ext_irq3_priority_o, |out_compare3_priority_o})
		else $error("upper enables wrong");
	// Enables may only move when a write lands
	chk_en_moves: assert property ($changed(src3_enabled_o) |-> $rose(s_axi_bvalid_o))
		else $error("enable moved without write");
	chk_fld_hold: assert property (!$rose(s_axi_bvalid_o) |-> $stable({ext_irq3_priority_o,
		out_compare3_priority_o, in_capture3_priority_o, timer3_priority_o}))
		else $error("priority moved without write");
	chk_sub_hold: assert property (!$rose(s_axi_bvalid_o) |->
		$stable({ext_irq3_subpriority_o, out_compare3_subpriority_o,
		in_capture3_subpriority_o, timer3_subpriority_o}))
		else $error("subpriority moved without write");
	chk_p4_hold: assert property (!$rose(s_axi_bvalid_o) |-> $stable(prio4_fields_o))
		else $error("second register moved");
	chk_rsvd_zero: assert property (s_axi_rvalid_o |-> (s_axi_rdata_o & ~PRIO_WR_MASK) == 32'h0)
		else $error("reserved bits read nonzero");
	chk_reset_clear: assert property
		($rose(rst_n_i) |-> src3_enabled_o == 4'h0 && prio4_fields_o == 32'h0)
		else $error("fields not cleared by reset");
	cover property ($rose(s_axi_bvalid_o));
	cover property (s_axi_rvalid_o);
	cover property (src3_enabled_o == 4'hF);
endmodule : irq_prio_checker
bind interrupt_priority_ctrl_slice irq_prio_checker i_irq_prio_checker (
	.clk_i                      (clk_i),
	.rst_n_i                    (rst_n_i),
	.s_axi_bvalid_o             (s_axi_bvalid_o),
	.s_axi_rvalid_o             (s_axi_rvalid_o),
	.s_axi_rdata_o              (s_axi_rdata_o),
	.ext_irq3_priority_o        (ext_irq3_priority_o),
	.out_compare3_priority_o    (out_compare3_priority_o),
	.in_capture3_priority_o     (in_capture3_priority_o),
	.timer3_priority_o          (timer3_priority_o),
	.ext_irq3_subpriority_o     (ext_irq3_subpriority_o),
	.out_compare3_subpriority_o (out_compare3_subpriority_o),
	.in_capture3_subpriority_o  (in_capture3_subpriority_o),
	.timer3_subpriority_o       (timer3_subpriority_o),
	.prio4_fields_o             (prio4_fields_o),
	.src3_enabled_o             (src3_enabled_o)
);

// >>> tb/tb.sv
// Self-checking bench for the interrupt priority slice
`timescale 1ns/10ps
module tb
	import irq_prio_pkg::*;
;
	logic clk_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
	logic s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic s_axi_rvalid_o;
	logic [3:0] s_axi_awaddr_i, s_axi_wstrb_i, s_axi_araddr_i, src3_enabled_o;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, prio4_fields_o, m3, m4;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, ext_irq3_subpriority_o, out_compare3_subpriority_o;
	logic [1:0] in_capture3_subpriority_o, timer3_subpriority_o;
	logic [2:0] ext_irq3_priority_o, out_compare3_priority_o, in_capture3_priority_o;
	logic [2:0] timer3_priority_o;
	int error_cnt, compares, n;
	interrupt_priority_ctrl_slice i_interrupt_priority_ctrl_slice (
		.clk_i                      (clk_i),
		.rst_n_i                    (rst_n_i),
		.s_axi_awaddr_i             (s_axi_awaddr_i),
		.s_axi_awvalid_i            (s_axi_awvalid_i),
		.s_axi_awready_o            (s_axi_awready_o),
		.s_axi_wdata_i              (s_axi_wdata_i),
		.s_axi_wstrb_i              (s_axi_wstrb_i),
		.s_axi_wvalid_i             (s_axi_wvalid_i),
		.s_axi_wready_o             (s_axi_wready_o),
		.s_axi_bresp_o              (s_axi_bresp_o),
		.s_axi_bvalid_o             (s_axi_bvalid_o),
		.s_axi_bready_i             (s_axi_bready_i),
		.s_axi_araddr_i             (s_axi_araddr_i),
		.s_axi_arvalid_i            (s_axi_arvalid_i),
		.s_axi_arready_o            (s_axi_arready_o),
		.s_axi_rdata_o              (s_axi_rdata_o),
		.s_axi_rresp_o              (s_axi_rresp_o),
		.s_axi_rvalid_o             (s_axi_rvalid_o),
		.s_axi_rready_i             (s_axi_rready_i),
		.ext_irq3_priority_o        (ext_irq3_priority_o),
		.ext_irq3_subpriority_o     (ext_irq3_subpriority_o),
		.out_compare3_priority_o    (out_compare3_priority_o),
		.out_compare3_subpriority_o (out_compare3_subpriority_o),
		.in_capture3_priority_o     (in_capture3_priority_o),
		.in_capture3_subpriority_o  (in_capture3_subpriority_o),
		.timer3_priority_o          (timer3_priority_o),
		.timer3_subpriority_o       (timer3_subpriority_o),
		.prio4_fields_o             (prio4_fields_o),
		.src3_enabled_o             (src3_enabled_o)
	);
	// 100 ns period
	always #50 clk_i = ~clk_i;
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic end_sim();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_sim
	// Fields and enables against the bench's copy of both registers
	task automatic ck_out();
		chk("fields", {10'h0, |m3[28:26], |m3[20:18], |m3[12:10], |m3[4:2], m3[28:24], m3[20:16],
			m3[12:8], m3[4:0]}, {10'h0, src3_enabled_o, ext_irq3_priority_o, ext_irq3_subpriority_o,
			out_compare3_priority_o, out_compare3_subpriority_o, in_capture3_priority_o,
			in_capture3_subpriority_o, timer3_priority_o, timer3_subpriority_o});
		chk("reg4", {2'h0, m4}, {2'h0, prio4_fields_o});
	endtask : ck_out
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		{s_axi_awaddr_i, s_axi_wdata_i, s_axi_wstrb_i} <= {a, d, s};
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
		for (n = 0; n < 64 && !(s_axi_bvalid_o && s_axi_bready_i); n++) begin
			@(posedge clk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end
		s_axi_bready_i <= 1'b0;
		if (n == 64) error_cnt++;
		if (n == 64) end_sim();
		chk("bresp", {(a == ADDR_PRIO3 || a == ADDR_PRIO4) ? RESP_OKAY : RESP_SLVERR, 32'h0},
			{s_axi_bresp_o, 32'h0});
		// Reserved bits never store, unmapped slots store nothing
		for (int b = 0; b < 4; b++) begin
			if (s[b] && a == ADDR_PRIO3) m3[8*b+:8] = d[8*b+:8] & PRIO_WR_MASK[8*b+:8];
			if (s[b] && a == ADDR_PRIO4) m4[8*b+:8] = d[8*b+:8] & PRIO_WR_MASK[8*b+:8];
		end
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
		for (n = 0; n < 64 && !(s_axi_rvalid_o && s_axi_rready_i); n++) begin
			@(posedge clk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end
		s_axi_rready_i <= 1'b0;
		if (n == 64) error_cnt++;
		if (n == 64) end_sim();
		chk("read", {(a == ADDR_PRIO3 || a == ADDR_PRIO4) ? RESP_OKAY : RESP_SLVERR,
			a == ADDR_PRIO3 ? m3 : a == ADDR_PRIO4 ? m4 : 32'h0},
			{s_axi_rresp_o, s_axi_rdata_o});
	endtask : rd
	initial begin
		{clk_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
		{s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i, s_axi_wdata_i, s_axi_wstrb_i} = '0;
		{s_axi_araddr_i, m3, m4, error_cnt, compares} = '0;
		n = $urandom(9196);
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		ck_out();
		rd(ADDR_PRIO3);
		// Every level and subpriority code in all four sources, zero first
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_PRIO3, {4{3'h0, 3'(i), 2'(i)}}, 4'hF);
			ck_out();
		end
		// Random lanes to both registers and the unmapped slot, back to back with reads
		for (int i = 0; i < 60; i++) begin
			wr(4'($urandom_range(2) * 4), $urandom & PRIO_WR_MASK, 4'($urandom));
			ck_out();
			rd(4'($urandom_range(2) * 4));
		end
		// Mid-run reset with every level set in both registers must clear them all
		wr(ADDR_PRIO3, 32'h1F1F_1F1F, 4'hF);
		wr(ADDR_PRIO4, 32'h1F1F_1F1F, 4'hF);
		ck_out();
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		{m3, m4} = '0;
		@(posedge clk_i);
		ck_out();
		rd(ADDR_PRIO3);
		rd(ADDR_PRIO4);
		end_sim();
	end
endmodule : tb
